// file: src/tob_pkg.sv
// types for the trim option bank
// assumes the constants header is included by the design file
package tob_pkg;
	typedef struct packed {
		logic       quarter_rate_select;
		logic       reserved_hi;
		logic [2:0] filter_delay_code;
		logic       reserved_lo;
		logic [1:0] filter_mode_field;
	} tob_filter_cfg_t;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic       hit;
		logic [2:0] index;
	} tob_ahb_req_t;
endpackage

// file: src/tob_regs.svh
// constants for the trim option bank: register word indices, reset values, timing
// assumes a 250 MHz system clock and 32-bit AHB-Lite word access
`ifndef TOB_REGS_SVH
`define TOB_REGS_SVH

`define TOB_IDX_REF      8'h20
`define TOB_IDX_CONV     8'h21
`define TOB_IDX_OSC      8'h22
`define TOB_IDX_BO       8'h23
`define TOB_IDX_FLT      8'h26
`define TOB_IDX_BASE     8'h20

`define TOB_FLT_RESET    8'h44
`define TOB_REF_FACTORY  8'h87
`define TOB_CONV_FACTORY 8'h80
`define TOB_OSC_FACTORY  8'h80
`define TOB_BO_FACTORY   8'hfc

`define TOB_CLK_PERIOD_PS 4000
`define TOB_DLY0_NS 5
`define TOB_DLY1_NS 7
`define TOB_DLY2_NS 9
`define TOB_DLY3_NS 11
`define TOB_DLY4_NS 13
`define TOB_DLY5_NS 17
`define TOB_DLY6_NS 20
`define TOB_DLY7_NS 25
`define TOB_NS_TO_CYC(ns) (((ns) * 1000 + `TOB_CLK_PERIOD_PS - 1) / `TOB_CLK_PERIOD_PS)

`endif

// file: src/tob_trim_bank.sv
// trim option bank: five trim bytes on AHB-Lite plus the clock glitch filter they steer
// assumes raw_clock_in is asynchronous to ref_clk_in and single-word AHB-Lite transfers
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ns
`include "tob_regs.svh"

module tob_trim_bank (
	input  wire logic        ref_clk_in,
	input  wire logic        resetn_in,
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic        hready_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        raw_clock_in,
	output logic      [31:0] hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	output logic      [4:0]  analog_reference_trim_field_out,
	output logic      [7:0]  converter_comparator_trim_byte_out,
	output logic      [7:0]  oscillator_trim_field_out,
	output logic      [2:0]  brownout_trim_field_out,
	output logic      [11:0] brownout_level_mv_out,
	output logic             brownout_level_valid_out,
	output logic             filtered_clock_out
);
	// trim storage except the filter byte models the information page: no reset, powered up with factory values
	logic [7:0]                ref_reg  = `TOB_REF_FACTORY;
	logic [7:0]                conv_reg = `TOB_CONV_FACTORY;
	logic [7:0]                osc_reg  = `TOB_OSC_FACTORY;
	logic [7:0]                bo_reg   = `TOB_BO_FACTORY;
	tob_pkg::tob_filter_cfg_t  flt_reg;
	tob_pkg::tob_ahb_req_t     req_reg;
	tob_pkg::tob_ahb_req_t     req_next;
	logic [31:0]               rdata_next;
	logic [11:0]               mv_reg;
	logic                      mv_valid_reg;
	logic                      sync1_reg;
	logic                      sync2_reg;
	logic                      filt_reg;
	logic [2:0]                cnt_reg;
	logic [1:0]                div_reg;
	logic                      out_reg;
	logic [2:0]                need_cyc;
	logic                      hold_low;
	logic                      hold_high;
	logic                      wr_now;

	// index of a byte address, hit only on the five mapped words
	function automatic logic [3:0] decode_addr(input logic [31:0] a);
		logic [7:0] w;
		w = a[9:2];
		if (a[31:10] != 22'h0 || a[1:0] != 2'h0)
			decode_addr = 4'h0;
		else if (w == `TOB_IDX_REF || w == `TOB_IDX_CONV || w == `TOB_IDX_OSC
			|| w == `TOB_IDX_BO || w == `TOB_IDX_FLT)
			decode_addr = {1'b1, 3'(w - `TOB_IDX_BASE)};
		else
			decode_addr = 4'h0;
	endfunction

	// least time rounds up to whole cycles
	function automatic logic [2:0] delay_cycles(input logic [2:0] code);
		case (code)
			3'h0: delay_cycles = 3'(`TOB_NS_TO_CYC(`TOB_DLY0_NS));
			3'h1: delay_cycles = 3'(`TOB_NS_TO_CYC(`TOB_DLY1_NS));
			3'h2: delay_cycles = 3'(`TOB_NS_TO_CYC(`TOB_DLY2_NS));
			3'h3: delay_cycles = 3'(`TOB_NS_TO_CYC(`TOB_DLY3_NS));
			3'h4: delay_cycles = 3'(`TOB_NS_TO_CYC(`TOB_DLY4_NS));
			3'h5: delay_cycles = 3'(`TOB_NS_TO_CYC(`TOB_DLY5_NS));
			3'h6: delay_cycles = 3'(`TOB_NS_TO_CYC(`TOB_DLY6_NS));
			default: delay_cycles = 3'(`TOB_NS_TO_CYC(`TOB_DLY7_NS));
		endcase
	endfunction

	// byte value held at a trim index
	function automatic logic [7:0] trim_byte(input logic [2:0] idx, input logic [7:0] r,
		input logic [7:0] c, input logic [7:0] o, input logic [7:0] b, input logic [7:0] f);
		case (idx)
			3'h0: trim_byte = r;
			3'h1: trim_byte = c;
			3'h2: trim_byte = o;
			3'h3: trim_byte = b;
			3'h6: trim_byte = f;
			default: trim_byte = 8'h00;
		endcase
	endfunction

	// address phase
	always_comb begin
		logic [3:0] d;
		d = decode_addr(haddr_in);
		req_next.valid = hsel_in && hready_in && htrans_in[1];
		req_next.write = hwrite_in;
		req_next.hit   = d[3];
		req_next.index = d[2:0];
	end

	assign wr_now = req_reg.valid && req_reg.write && req_reg.hit;

	// read data is sampled in the address phase; a write in its data phase is bypassed
	// so back-to-back write then read returns the new byte
	always_comb begin
		logic [7:0] r;
		logic [7:0] c;
		logic [7:0] o;
		logic [7:0] b;
		logic [7:0] f;
		r = ref_reg;
		c = conv_reg;
		o = osc_reg;
		b = bo_reg;
		f = flt_reg;
		if (wr_now) begin
			case (req_reg.index)
				3'h0: r = hwdata_in[7:0];
				3'h1: c = hwdata_in[7:0];
				3'h2: o = hwdata_in[7:0];
				3'h3: b = hwdata_in[7:0];
				3'h6: f = hwdata_in[7:0];
				default: r = ref_reg;
			endcase
		end
		rdata_next = 32'h0;
		if (req_next.valid && !req_next.write && req_next.hit)
			rdata_next = {24'h0, trim_byte(req_next.index, r, c, o, b, f)};
	end

	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			req_reg       <= '0;
			hrdata_out    <= 32'h0;
			hreadyout_out <= 1'b0;
			hresp_out     <= 1'b0;
		end else begin
			req_reg       <= req_next;
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
			if (req_next.valid)
				hrdata_out <= rdata_next;
		end
	end

	// unmapped writes are dropped; writes are never refused (always OKAY)
	always_ff @(posedge ref_clk_in) begin
		if (resetn_in && wr_now) begin
			case (req_reg.index)
				3'h0: ref_reg  <= hwdata_in[7:0];
				3'h1: conv_reg <= hwdata_in[7:0];
				3'h2: osc_reg  <= hwdata_in[7:0];
				3'h3: bo_reg   <= hwdata_in[7:0];
				default: ref_reg <= ref_reg;
			endcase
		end
	end

	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			flt_reg <= `TOB_FLT_RESET;
		else if (wr_now && req_reg.index == 3'h6)
			flt_reg <= hwdata_in[7:0];
	end

	assign analog_reference_trim_field_out    = ref_reg[7:3];
	assign converter_comparator_trim_byte_out = conv_reg;
	assign oscillator_trim_field_out          = osc_reg;
	assign brownout_trim_field_out            = bo_reg[2:0];
	assign brownout_level_mv_out              = mv_reg;
	assign brownout_level_valid_out           = mv_valid_reg;
	assign filtered_clock_out                 = out_reg;

	// brown-out trigger level in millivolts
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			mv_reg       <= 12'h0;
			mv_valid_reg <= 1'b0;
		end else begin
			mv_valid_reg <= 1'b1;
			case (bo_reg[2:0])
				3'h1: mv_reg <= 12'h640;
				3'h0: mv_reg <= 12'h6a4;
				3'h7: mv_reg <= 12'h708;
				3'h6: mv_reg <= 12'h7d0;
				3'h5: mv_reg <= 12'h898;
				3'h4: mv_reg <= 12'h960;
				default: begin
					mv_reg       <= 12'h0;
					mv_valid_reg <= 1'b0;
				end
			endcase
		end
	end

	// raw clock is asynchronous: two flops before anything looks at it
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
		end else begin
			sync1_reg <= raw_clock_in;
			sync2_reg <= sync1_reg;
		end
	end

	assign need_cyc  = delay_cycles(flt_reg.filter_delay_code);
	assign hold_high = flt_reg.filter_mode_field[0];
	assign hold_low  = flt_reg.filter_mode_field[1];

	// sampling limits resolution to one 4 ns cycle; the analog filter varies about 30% anyway
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			filt_reg <= 1'b0;
			cnt_reg  <= 3'h0;
		end else if (sync2_reg == filt_reg) begin
			cnt_reg <= 3'h0;
		end else if ((filt_reg && !hold_high) || (!filt_reg && !hold_low)) begin
			filt_reg <= sync2_reg;
			cnt_reg  <= 3'h0;
		end else if (cnt_reg + 3'h1 >= need_cyc) begin
			filt_reg <= sync2_reg;
			cnt_reg  <= 3'h0;
		end else begin
			cnt_reg <= cnt_reg + 3'h1;
		end
	end

	// divider follows the filter, counting filtered rising edges
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			div_reg <= 2'h0;
			out_reg <= 1'b0;
		end else begin
			if (sync2_reg != filt_reg && !filt_reg && cnt_reg + 3'h1 >= need_cyc)
				div_reg <= div_reg + 2'h1;
			else if (sync2_reg && !filt_reg && !hold_low)
				div_reg <= div_reg + 2'h1;
			if (flt_reg.quarter_rate_select)
				out_reg <= div_reg[1];
			else
				out_reg <= filt_reg;
		end
	end

	AST_READ_FILTER_BYTE: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		(req_next.valid && !hwrite_in && haddr_in == 32'h98 && !wr_now)
		|=> hrdata_out == {24'h0, $past(flt_reg)})
		else $error("filter byte read at its address returned wrong data");

	AST_OSC_WRITE: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		(wr_now && req_reg.index == 3'h2) |=> oscillator_trim_field_out == $past(hwdata_in[7:0]))
		else $error("oscillator trim write not stored");

	AST_BO_LEVEL: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		(bo_reg[2:0] == 3'h0) ##1 (bo_reg[2:0] == 3'h0) |-> brownout_level_mv_out == 12'h6a4
			&& brownout_level_valid_out)
		else $error("brown-out code 000 not decoded to 1.7 V");

	AST_FLT_RESET: assert property (@(posedge ref_clk_in)
		$rose(resetn_in) |-> flt_reg == `TOB_FLT_RESET)
		else $error("filter byte not 44h after reset");

	AST_TRIM_KEPT: assert property (@(posedge ref_clk_in)
		!resetn_in |=> osc_reg == $past(osc_reg) && bo_reg == $past(bo_reg) && ref_reg == $past(ref_reg))
		else $error("reset changed a kept trim byte");

	AST_NO_FILTER: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		(flt_reg.filter_mode_field == 2'h0) |=> filt_reg == $past(sync2_reg))
		else $error("unfiltered mode did not pass the input through");

	AST_LOW_GLITCH: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		(filt_reg && hold_high && !sync2_reg && cnt_reg == 3'h0 && need_cyc >= 3'h2) |=> filt_reg)
		else $error("short low glitch passed the filter");

	AST_HIGH_SETTLE: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		(!filt_reg && hold_low && sync2_reg && cnt_reg + 3'h1 == need_cyc) |=> filt_reg)
		else $error("high level not accepted after the delay");

	AST_FULL_RATE: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		(!flt_reg.quarter_rate_select && $past(flt_reg.quarter_rate_select) == 1'b0)
			##1 !flt_reg.quarter_rate_select |-> filtered_clock_out == $past(filt_reg))
		else $error("full rate output does not follow the filter");
endmodule

// file: verification/tob_trim_bank_bench.sv
// bench for the trim option bank: bus access, reset retention, brown-out levels, clock filter
// assumes an AHB-Lite slave that answers within 40 cycles and a raw clock driven in step with the system clock
`timescale 1ns/1ns
module tob_trim_bank_bench;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        raw = 1'b0;
	logic [31:0] hrdata;
	logic        hready;
	logic        hresp;
	logic [4:0]  ref_f;
	logic [7:0]  conv_b;
	logic [7:0]  osc_f;
	logic [2:0]  bo_f;
	logic [11:0] bo_mv;
	logic        bo_ok;
	logic        fclk;
	logic [31:0] rd;
	int          n_mismatch = 0;
	int          checks = 0;

	tob_trim_bank tob_trim_bank_inst (
		.ref_clk_in                         (clk),
		.resetn_in                          (rst_n),
		.hsel_in                            (hsel),
		.haddr_in                           (haddr),
		.htrans_in                          (htrans),
		.hwrite_in                          (hwrite),
		.hsize_in                           (3'h2),
		.hready_in                          (hready),
		.hwdata_in                          (hwdata),
		.raw_clock_in                       (raw),
		.hrdata_out                         (hrdata),
		.hreadyout_out                      (hready),
		.hresp_out                          (hresp),
		.analog_reference_trim_field_out    (ref_f),
		.converter_comparator_trim_byte_out (conv_b),
		.oscillator_trim_field_out          (osc_f),
		.brownout_trim_field_out            (bo_f),
		.brownout_level_mv_out              (bo_mv),
		.brownout_level_valid_out           (bo_ok),
		.filtered_clock_out                 (fclk)
	);

	initial begin
		forever #2 clk = ~clk;
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// every wait is bounded; a slave that never answers ends the run
	task automatic wait_rdy();
		int i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (hready !== 1'b1 && i < 40);
		if (hready !== 1'b1) begin
			n_mismatch++;
			$display("MISMATCH %0t bus hang", $time);
			final_report();
		end
	endtask

	// one single-word transfer; byte address is four times the trim index
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'b00};
		hwrite <= wr;
		htrans <= 2'h2;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		wait_rdy();
		rd = hrdata;
	endtask

	task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h0);
		chk(rd, {24'h0, exp});
	endtask

	function automatic logic [11:0] mv(input logic [2:0] c);
		case (c)
			3'h0: return 12'h6a4;
			3'h1: return 12'h640;
			3'h4: return 12'h960;
			3'h5: return 12'h898;
			3'h6: return 12'h7d0;
			3'h7: return 12'h708;
			default: return 12'h0;
		endcase
	endfunction

	// one pulse of w cycles away from base; pass says whether the output is expected to follow it
	task automatic glitch(input logic [7:0] cfg, input logic base, input int w, input logic pass);
		logic seen = 1'b0;
		bus(1'b1, 8'h26, cfg);
		raw <= base;
		repeat (20) @(posedge clk);
		for (int i = 0; i < 40; i++) begin
			raw <= (i > 0 && i <= w) ? ~base : base;
			@(posedge clk);
			if (fclk !== base)
				seen = 1'b1;
		end
		chk({31'h0, seen}, {31'h0, pass});
	endtask

	// raw clock of four cycles per period; counts output rising edges
	task automatic rate(input logic [7:0] cfg, input int lo, input int hi);
		int n = 0;
		logic last;
		bus(1'b1, 8'h26, cfg);
		last = fclk;
		for (int i = 0; i < 64; i++) begin
			raw <= i[1];
			@(posedge clk);
			if (fclk === 1'b1 && last === 1'b0)
				n++;
			last = fclk;
		end
		chk({31'h0, n >= lo && n <= hi}, 32'h1);
	endtask

	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd_chk(8'h20, 8'h87);
		rd_chk(8'h21, 8'h80);
		rd_chk(8'h22, 8'h80);
		rd_chk(8'h23, 8'hfc);
		rd_chk(8'h26, 8'h44);
		chk({31'h0, hresp}, 32'h0);
		bus(1'b1, 8'h24, 8'h5a);
		rd_chk(8'h24, 8'h00);
		bus(1'b1, 8'h20, 8'haf);
		bus(1'b1, 8'h22, 8'h5a);
		// outputs launched at the write's last edge are looked at one edge later
		@(posedge clk);
		chk({27'h0, ref_f}, 32'h15);
		chk({24'h0, osc_f}, 32'h5a);
		chk({24'h0, conv_b}, 32'h80);
		for (int c = 0; c < 8; c++) begin
			bus(1'b1, 8'h23, {5'h1f, c[2:0]});
			// the level register follows the stored byte one cycle later
			repeat (2) @(posedge clk);
			chk({29'h0, bo_f}, {29'h0, c[2:0]});
			chk({20'h0, bo_mv}, {20'h0, mv(c[2:0])});
			chk({31'h0, bo_ok}, {31'h0, c[2:1] != 2'h1});
		end
		bus(1'b1, 8'h26, 8'hd5);
		rd_chk(8'h26, 8'hd5);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd_chk(8'h20, 8'haf);
		rd_chk(8'h22, 8'h5a);
		rd_chk(8'h23, 8'hff);
		rd_chk(8'h26, 8'h44);
		glitch(8'h44, 1'b1, 1, 1'b1);
		glitch(8'h45, 1'b1, 1, 1'b0);
		glitch(8'h45, 1'b0, 1, 1'b1);
		glitch(8'h46, 1'b0, 1, 1'b0);
		glitch(8'h46, 1'b1, 1, 1'b1);
		glitch(8'h7f, 1'b0, 6, 1'b0);
		glitch(8'h7f, 1'b1, 6, 1'b0);
		glitch(8'h7f, 1'b0, 10, 1'b1);
		rate(8'h44, 14, 16);
		rate(8'hc4, 3, 5);
		final_report();
	end
endmodule
